// ==== verilog/mpam_pkg.sv ====
// Notes on behaviour
// - Count every valid message in a read-only 16-bit counter starting at zero.
// - Count messages with a failed CRC in a read-only 16-bit counter from zero.
// - Count messages with any other communication error in a separate 16-bit counter; one that also fails its CRC counts only in the CRC counter.
// - Each 16-bit register travels high byte first, low byte last.
// - Word order 0: first register holds low word, second holds high word.
// - Word order 1, the reset default: first register holds the high word.
// - Address mode selects the register-to-parameter mapping over the 16-bit space.
// - Mode 0, 16-bit: address is 100*group+index, groups 1-199, indexes 1-99.
// - Mode 0, 32-bit: address is 20000+200*group+2*index, groups 1-199, indexes 1-99.
// - Mode 1, 16-bit: address is 256*group+index, groups and indexes 1-255.
// - Mode 2, 32-bit: address is 512*group+2*index, groups 1-127, indexes 1-255.
// - Mode 3, 32-bit: address is 256*group+2*index, groups 1-255, indexes 1-127.
package mpam_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 32;
  localparam logic [REG_AW-1:0] IDX_VALID_CNT = 8'h08;
  localparam logic [REG_AW-1:0] IDX_CRC_CNT = 8'h09;
  localparam logic [REG_AW-1:0] IDX_OTHER_CNT = 8'h0a;
  localparam logic [REG_AW-1:0] IDX_WORD_ORDER = 8'h0b;
  localparam logic [REG_AW-1:0] IDX_ADDR_MODE = 8'h0c;
  localparam logic [REG_AW-1:0] IDX_IRQ_STATUS = 8'h10;
  localparam logic [REG_AW-1:0] IDX_IRQ_MASK = 8'h11;
  localparam logic [REG_AW-1:0] ADDR_VALID_CNT = 8'h20;
  localparam logic [REG_AW-1:0] ADDR_CRC_CNT = 8'h24;
  localparam logic [REG_AW-1:0] ADDR_OTHER_CNT = 8'h28;
  localparam logic [REG_AW-1:0] ADDR_WORD_ORDER = 8'h2c;
  localparam logic [REG_AW-1:0] ADDR_ADDR_MODE = 8'h30;
  localparam logic [REG_AW-1:0] ADDR_IRQ_STATUS = 8'h40;
  localparam logic [REG_AW-1:0] ADDR_IRQ_MASK = 8'h44;

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic WORD_ORDER_RST = 1'h1;
  localparam logic [1:0] ADDR_MODE_RST = 2'h0;
  localparam int unsigned IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam int unsigned IRQ_CRC = 0;
  localparam int unsigned IRQ_OTHER = 1;
  localparam int unsigned IRQ_ADDR = 2;
  localparam int unsigned IRQ_SAT = 3;
  localparam logic low_word_first = 1'h0;
  localparam logic high_word_first = 1'h1;

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 16;
  localparam int unsigned CNT_N = 3;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

  // ----------------------------------------------------------------
  // Address mapping
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [1:0] MODE_3 = 2'h3;
  localparam logic [15:0] M0_NARROW_MUL = 16'h0064;
  localparam logic [15:0] M0_WIDE_BASE = 16'h4e20;
  localparam logic [15:0] M0_WIDE_MUL = 16'h00c8;
  localparam logic [15:0] M0_GROUP_MAX = 16'h00c7;
  localparam logic [15:0] M0_INDEX_MAX = 16'h0063;
  localparam logic [15:0] M1_GROUP_MAX = 16'h00ff;
  localparam logic [15:0] M1_INDEX_MAX = 16'h00ff;
  localparam logic [15:0] M2_GROUP_MAX = 16'h007f;
  localparam logic [15:0] M2_INDEX_MAX = 16'h00ff;
  localparam logic [15:0] M3_GROUP_MAX = 16'h00ff;
  localparam logic [15:0] M3_INDEX_MAX = 16'h007f;
  localparam logic [15:0] GROUP_MIN = 16'h0001;
  localparam logic [15:0] INDEX_MIN = 16'h0001;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;

endpackage

// ==== verilog/mpam_sat_cnt.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Saturating message counter
// ------------------------------------------------------------------
module mpam_sat_cnt (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // Count event
  input wire logic inc_i,
  // State
  output logic [mpam_pkg::CNT_W-1:0] count_o,
  output logic sat_o
);

  // Holding at the top keeps a long run from looking like a quiet link.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= mpam_pkg::CNT_RST;
      sat_o <= 1'b0;
    end else if (en_i) begin
      sat_o <= 1'b0;
      if (inc_i && count_o != mpam_pkg::CNT_MAX) begin
        count_o <= count_o + 16'h0001;
        sat_o <= (count_o == mpam_pkg::CNT_MAX - 16'h0001);
      end
    end
  end

endmodule

// ==== verilog/mpam_word_pack.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Response word selection and byte ordering
// ------------------------------------------------------------------
module mpam_word_pack (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // Load
  input wire logic load_i,
  input wire logic exc_i,
  input wire logic wide_i,
  input wire logic high_i,
  input wire logic [31:0] data_i,
  // Response
  output logic valid_o,
  output logic exc_o,
  output logic [7:0] exc_code_o,
  output logic [7:0] byte_first_o,
  output logic [7:0] byte_second_o
);

  logic [15:0] word;

  always_comb begin
    word = data_i[15:0];
    if (wide_i && high_i) begin
      word = data_i[31:16];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_o <= 1'b0;
      exc_o <= 1'b0;
      exc_code_o <= 8'h00;
      byte_first_o <= 8'h00;
      byte_second_o <= 8'h00;
    end else if (en_i) begin
      valid_o <= load_i;
      if (load_i) begin
        exc_o <= exc_i;
        exc_code_o <= exc_i ? mpam_pkg::EXC_ILLEGAL_ADDR : 8'h00;
        byte_first_o <= exc_i ? 8'h00 : word[15:8];
        byte_second_o <= exc_i ? 8'h00 : word[7:0];
      end
    end
  end

endmodule

// ==== verilog/mpam_param_map.sv ====
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Holding-register to drive-parameter address map
// ------------------------------------------------------------------
module mpam_param_map (
  // Clock, reset and clock enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // Register port
  input wire logic [mpam_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic [mpam_pkg::REG_DW-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [mpam_pkg::REG_DW-1:0] reg_rdata_o,
  // Message outcome pulses from the frame receiver
  input wire logic msg_ok_i,
  input wire logic msg_crc_err_i,
  input wire logic msg_other_err_i,
  // Holding-register request from the frame receiver
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [7:0] req_byte_first_i,
  input wire logic [7:0] req_byte_second_i,
  // Parameter store access
  output logic par_req_o,
  output logic par_write_o,
  output logic [7:0] par_group_o,
  output logic [7:0] par_index_o,
  output logic par_wide_o,
  output logic par_high_word_o,
  output logic [15:0] par_wdata_o,
  input wire logic par_done_i,
  input wire logic [31:0] par_rdata_i,
  // Response to the frame transmitter
  output logic rsp_valid_o,
  output logic rsp_exc_o,
  output logic [7:0] rsp_exc_code_o,
  output logic [7:0] rsp_byte_first_o,
  output logic [7:0] rsp_byte_second_o,
  // Interrupt
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic word_order_r;
  logic [1:0] addr_mode_r;
  logic [mpam_pkg::IRQ_W-1:0] irq_mask_r;
  logic [mpam_pkg::IRQ_W-1:0] irq_status_r;
  logic [mpam_pkg::IRQ_W-1:0] irq_status_nxt;
  logic [mpam_pkg::IRQ_W-1:0] irq_event;
  logic irq_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_order_r <= mpam_pkg::WORD_ORDER_RST;
    end else if (en_i && reg_we_i && reg_addr_i == mpam_pkg::ADDR_WORD_ORDER) begin
      word_order_r <= reg_wdata_i[0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_mode_r <= mpam_pkg::ADDR_MODE_RST;
    end else if (en_i && reg_we_i && reg_addr_i == mpam_pkg::ADDR_ADDR_MODE) begin
      addr_mode_r <= reg_wdata_i[1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_r <= mpam_pkg::IRQ_MASK_RST;
    end else if (en_i && reg_we_i && reg_addr_i == mpam_pkg::ADDR_IRQ_MASK) begin
      irq_mask_r <= reg_wdata_i[mpam_pkg::IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Message counters
  // ----------------------------------------------------------------
  logic [mpam_pkg::CNT_N-1:0] cnt_inc;
  logic [mpam_pkg::CNT_N-1:0] cnt_sat;
  logic [mpam_pkg::CNT_W-1:0] cnt_val [mpam_pkg::CNT_N];

  // A message flagged both ways counts once, as its worst error.
  always_comb begin
    cnt_inc[0] = msg_ok_i && !msg_crc_err_i && !msg_other_err_i;
    cnt_inc[1] = msg_crc_err_i;
    cnt_inc[2] = msg_other_err_i && !msg_crc_err_i;
  end

  genvar gi;
  generate
    for (gi = 0; gi < mpam_pkg::CNT_N; gi = gi + 1) begin : g_cnt
      mpam_sat_cnt u_cnt (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .en_i(en_i),
        .inc_i(cnt_inc[gi]),
        .count_o(cnt_val[gi]),
        .sat_o(cnt_sat[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [15:0] dec_group;
  logic [15:0] dec_index;
  logic [15:0] dec_off;
  logic [15:0] dec_rem;
  logic [15:0] grp_max;
  logic [15:0] idx_max;
  logic dec_wide;
  logic dec_second;
  logic dec_ok;

  always_comb begin
    dec_off = 16'h0000;
    dec_rem = 16'h0000;
    dec_group = 16'h0000;
    dec_index = 16'h0000;
    dec_wide = 1'b0;
    dec_second = 1'b0;
    grp_max = mpam_pkg::M0_GROUP_MAX;
    idx_max = mpam_pkg::M0_INDEX_MAX;
    case (addr_mode_r)
      mpam_pkg::MODE_0: begin
        if (req_addr_i < mpam_pkg::M0_WIDE_BASE) begin
          dec_group = req_addr_i / mpam_pkg::M0_NARROW_MUL;
          dec_index = req_addr_i % mpam_pkg::M0_NARROW_MUL;
        end else begin
          dec_off = req_addr_i - mpam_pkg::M0_WIDE_BASE;
          dec_group = dec_off / mpam_pkg::M0_WIDE_MUL;
          dec_rem = dec_off % mpam_pkg::M0_WIDE_MUL;
          dec_index = {1'b0, dec_rem[15:1]};
          dec_second = dec_rem[0];
          dec_wide = 1'b1;
        end
      end
      mpam_pkg::MODE_1: begin
        dec_group = {8'h00, req_addr_i[15:8]};
        dec_index = {8'h00, req_addr_i[7:0]};
        grp_max = mpam_pkg::M1_GROUP_MAX;
        idx_max = mpam_pkg::M1_INDEX_MAX;
      end
      mpam_pkg::MODE_2: begin
        dec_group = {9'h000, req_addr_i[15:9]};
        dec_index = {8'h00, req_addr_i[8:1]};
        dec_second = req_addr_i[0];
        dec_wide = 1'b1;
        grp_max = mpam_pkg::M2_GROUP_MAX;
        idx_max = mpam_pkg::M2_INDEX_MAX;
      end
      mpam_pkg::MODE_3: begin
        dec_group = {8'h00, req_addr_i[15:8]};
        dec_index = {9'h000, req_addr_i[7:1]};
        dec_second = req_addr_i[0];
        dec_wide = 1'b1;
        grp_max = mpam_pkg::M3_GROUP_MAX;
        idx_max = mpam_pkg::M3_INDEX_MAX;
      end
      default: begin
        dec_group = 16'h0000;
      end
    endcase
    // Group or index zero is not a parameter in any mode.
    dec_ok = dec_group >= mpam_pkg::GROUP_MIN && dec_group <= grp_max &&
             dec_index >= mpam_pkg::INDEX_MIN && dec_index <= idx_max;
  end

  // ----------------------------------------------------------------
  // Parameter access
  // ----------------------------------------------------------------
  logic busy_r;
  logic ctx_wide_r;
  logic ctx_high_r;
  logic high_sel;
  logic rsp_load;
  logic rsp_exc;

  // With order 1 the even register of a pair is the high word.
  assign high_sel = dec_wide && (word_order_r ^ dec_second);

  // A request that arrives while a parameter access is open is dropped;
  // the frame receiver serves one request at a time.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      par_req_o <= 1'b0;
      par_write_o <= 1'b0;
      par_group_o <= 8'h00;
      par_index_o <= 8'h00;
      par_wide_o <= 1'b0;
      par_high_word_o <= 1'b0;
      par_wdata_o <= 16'h0000;
    end else if (en_i) begin
      par_req_o <= req_valid_i && !busy_r && dec_ok;
      if (req_valid_i && !busy_r && dec_ok) begin
        par_write_o <= req_write_i;
        par_group_o <= dec_group[7:0];
        par_index_o <= dec_index[7:0];
        par_wide_o <= dec_wide;
        par_high_word_o <= high_sel;
        par_wdata_o <= {req_byte_first_i, req_byte_second_i};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_r <= 1'b0;
      ctx_wide_r <= 1'b0;
      ctx_high_r <= 1'b0;
    end else if (en_i) begin
      if (req_valid_i && !busy_r && dec_ok) begin
        busy_r <= 1'b1;
        ctx_wide_r <= dec_wide;
        ctx_high_r <= high_sel;
      end else if (par_done_i) begin
        busy_r <= 1'b0;
      end
    end
  end

  assign rsp_exc = req_valid_i && !busy_r && !dec_ok;
  assign rsp_load = rsp_exc || (busy_r && par_done_i);

  mpam_word_pack u_pack (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(en_i),
    .load_i(rsp_load),
    .exc_i(rsp_exc),
    .wide_i(ctx_wide_r),
    .high_i(ctx_high_r),
    .data_i(par_rdata_i),
    .valid_o(rsp_valid_o),
    .exc_o(rsp_exc_o),
    .exc_code_o(rsp_exc_code_o),
    .byte_first_o(rsp_byte_first_o),
    .byte_second_o(rsp_byte_second_o)
  );

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  always_comb begin
    irq_event = '0;
    irq_event[mpam_pkg::IRQ_CRC] = cnt_inc[1];
    irq_event[mpam_pkg::IRQ_OTHER] = cnt_inc[2];
    irq_event[mpam_pkg::IRQ_ADDR] = rsp_exc;
    irq_event[mpam_pkg::IRQ_SAT] = |cnt_sat;
    irq_status_nxt = irq_status_r;
    if (reg_we_i && reg_addr_i == mpam_pkg::ADDR_IRQ_STATUS) begin
      irq_status_nxt = irq_status_r & ~reg_wdata_i[mpam_pkg::IRQ_W-1:0];
    end
    // An event in the clearing cycle survives the clear.
    irq_status_nxt = irq_status_nxt | irq_event;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_status_r <= '0;
      irq_r <= 1'b0;
    end else if (en_i) begin
      irq_status_r <= irq_status_nxt;
      irq_r <= |(irq_status_nxt & irq_mask_r);
    end
  end

  assign irq_o = irq_r;

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  logic [mpam_pkg::REG_DW-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (reg_addr_i)
      mpam_pkg::ADDR_VALID_CNT: rd_mux = {16'h0000, cnt_val[0]};
      mpam_pkg::ADDR_CRC_CNT: rd_mux = {16'h0000, cnt_val[1]};
      mpam_pkg::ADDR_OTHER_CNT: rd_mux = {16'h0000, cnt_val[2]};
      mpam_pkg::ADDR_WORD_ORDER: rd_mux = {31'h00000000, word_order_r};
      mpam_pkg::ADDR_ADDR_MODE: rd_mux = {30'h00000000, addr_mode_r};
      mpam_pkg::ADDR_IRQ_STATUS: rd_mux = {28'h0000000, irq_status_r};
      mpam_pkg::ADDR_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_r};
      default: rd_mux = '0;
    endcase
  end

  // Data stand only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else if (en_i) begin
      reg_rdata_o <= reg_re_i ? rd_mux : '0;
    end
  end

endmodule

// ==== dv/mpam_store_model.sv ====
`timescale 1ns/1ps
// ----------
// Parameter store stand-in
// ----------
module mpam_store_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Access
  input wire logic req_i,
  input wire logic slow_i,
  input wire logic [7:0] group_i,
  input wire logic [7:0] index_i,
  output logic done_o,
  output logic [31:0] rdata_o
);
  logic [2:0] wait_r;
  logic busy_r;
  // The data bus toggles between answers so that a stale word never passes for a fresh one.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_r <= 1'h0;
      wait_r <= 3'h0;
      done_o <= 1'h0;
      rdata_o <= 32'h0;
    end else begin
      done_o <= 1'h0;
      rdata_o <= ~rdata_o;
      if (req_i) begin
        busy_r <= 1'h1;
        wait_r <= slow_i ? 3'h6 : 3'h0;
      end else if (busy_r && wait_r != 3'h0) begin
        wait_r <= wait_r - 3'h1;
      end else if (busy_r) begin
        busy_r <= 1'h0;
        done_o <= 1'h1;
        rdata_o <= {group_i, index_i, ~group_i, ~index_i};
      end
    end
  end
endmodule

// ==== dv/mpam_param_map_props.sv ====
`timescale 1ns/1ps
// ----------
// Port checks
// ----------
module mpam_param_map_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic reg_re_i,
  input wire logic [mpam_pkg::REG_DW-1:0] reg_rdata_o,
  // Parameter access
  input wire logic req_valid_i,
  input wire logic par_req_o,
  input wire logic [7:0] par_group_o,
  input wire logic [7:0] par_index_o,
  input wire logic par_wide_o,
  input wire logic par_high_word_o,
  input wire logic par_done_i,
  input wire logic [31:0] par_rdata_i,
  // Response
  input wire logic rsp_valid_o,
  input wire logic rsp_exc_o,
  input wire logic [7:0] rsp_exc_code_o,
  input wire logic [7:0] rsp_byte_first_o,
  input wire logic [7:0] rsp_byte_second_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Store data is valid only with done, so a copy is kept for the reply cycle.
  logic [31:0] done_data_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_data_r <= 32'h0;
    end else begin
      done_data_r <= par_rdata_i;
    end
  end
  sequence s_refused;
    rsp_valid_o && rsp_exc_o;
  endsequence
  sequence s_reply;
    ##1 rsp_valid_o && !rsp_exc_o;
  endsequence
  chk_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == '0)
    else $error("read data outside its slot");
  chk_par_cause: assert property (par_req_o |-> $past(req_valid_i))
    else $error("parameter access without request");
  chk_par_pulse: assert property (par_req_o |=> !par_req_o)
    else $error("parameter access longer than one cycle");
  chk_group_legal: assert property (
    par_req_o |-> par_group_o != 8'h00 && par_index_o != 8'h00)
    else $error("zero group or index reached the store");
  chk_exc_form: assert property (s_refused |-> !par_req_o &&
    rsp_exc_code_o == mpam_pkg::EXC_ILLEGAL_ADDR && rsp_byte_first_o == 8'h00)
    else $error("malformed exception reply");
  chk_done_reply: assert property (par_done_i |-> s_reply)
    else $error("no reply after store done");
  chk_rsp_cause: assert property (rsp_valid_o && !rsp_exc_o |-> $past(par_done_i))
    else $error("reply without store done");
  chk_byte_order: assert property (rsp_valid_o && !rsp_exc_o |->
    {rsp_byte_first_o, rsp_byte_second_o} ==
    (par_wide_o && par_high_word_o ? done_data_r[31:16] : done_data_r[15:0]))
    else $error("reply bytes do not match store word");
endmodule

bind mpam_param_map mpam_param_map_props props_u (
  .clk_i, .rst_n_i, .reg_re_i, .reg_rdata_o, .req_valid_i, .par_req_o, .par_group_o,
  .par_index_o, .par_wide_o, .par_high_word_o, .par_done_i, .par_rdata_i, .rsp_valid_o,
  .rsp_exc_o, .rsp_exc_code_o, .rsp_byte_first_o, .rsp_byte_second_o
);

// ==== dv/test_mpam_param_map.sv ====
`timescale 1ns/1ps
// ----------
// Bench
// ----------
module test_mpam_param_map;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic en = 1'h1;
  logic we = 1'h0;
  logic re = 1'h0;
  logic ok = 1'h0;
  logic crc = 1'h0;
  logic oth = 1'h0;
  logic rv = 1'h0;
  logic rw = 1'h0;
  logic slow = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [15:0] ra = 16'h0;
  logic [7:0] b1 = 8'h00;
  logic [7:0] b2 = 8'h00;
  logic [31:0] rdata, prd;
  logic preq, pwr, pwide, phi, pdone, rsp, exc, irq;
  logic [7:0] grp, idx, code, o1, o2;
  logic [15:0] pwd;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  initial forever #5 clk_i = ~clk_i;

  mpam_param_map dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .msg_ok_i(ok),
    .msg_crc_err_i(crc), .msg_other_err_i(oth), .req_valid_i(rv), .req_write_i(rw),
    .req_addr_i(ra), .req_byte_first_i(b1), .req_byte_second_i(b2), .par_req_o(preq),
    .par_write_o(pwr), .par_group_o(grp), .par_index_o(idx), .par_wide_o(pwide),
    .par_high_word_o(phi), .par_wdata_o(pwd), .par_done_i(pdone), .par_rdata_i(prd),
    .rsp_valid_o(rsp), .rsp_exc_o(exc), .rsp_exc_code_o(code), .rsp_byte_first_o(o1),
    .rsp_byte_second_o(o2), .irq_o(irq));
  mpam_store_model store_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(preq), .slow_i(slow),
    .group_i(grp), .index_i(idx), .done_o(pdone), .rdata_o(prd));

  task automatic wrap_up;
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      $display("ERROR %0t run too long", $time);
      wrap_up();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    we <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    we <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    re <= 1'h1;
    addr <= a;
    @(posedge clk_i);
    re <= 1'h0;
    #1;
    cmp(rdata, exp);
  endtask

  task automatic pulse(input logic k, input logic c, input logic o);
    @(posedge clk_i);
    ok <= k;
    crc <= c;
    oth <= o;
    @(posedge clk_i);
    ok <= 1'h0;
    crc <= 1'h0;
    oth <= 1'h0;
  endtask

  task automatic irq_chk(input logic exp);
    @(posedge clk_i);
    #1;
    cmp(irq, exp);
  endtask

  // One holding-register access; a wait of up to 20 cycles covers the slow store.
  task automatic map(input logic [1:0] m, input logic ord, input logic [15:0] a,
    input logic bad, input logic [7:0] g, input logic [7:0] i, input logic wd,
    input logic hi);
    int n;
    logic seen;
    logic [15:0] ex;
    wr(8'h30, {30'h0, m});
    wr(8'h2c, {31'h0, ord});
    @(posedge clk_i);
    rv <= 1'h1;
    ra <= a;
    slow <= ~slow;
    @(posedge clk_i);
    rv <= 1'h0;
    #1;
    n = 0;
    seen = (preq === 1'h1);
    while (rsp !== 1'h1 && n < 20) begin
      seen = seen | (preq === 1'h1);
      @(posedge clk_i);
      #1;
      n++;
    end
    ex = (wd && hi) ? {g, i} : ~{g, i};
    if (bad) begin
      cmp({seen, rsp, exc, code, o1, o2}, {3'h3, 8'h02, 16'h0});
    end else begin
      cmp({seen, rsp, exc, pwide, phi, grp, idx}, {3'h6, wd, hi, g, i});
      cmp({o1, o2}, ex);
    end
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'h1;
    rd_chk(8'h20, 32'h0);
    rd_chk(8'h24, 32'h0);
    rd_chk(8'h28, 32'h0);
    rd_chk(8'h2c, 32'h1);
    rd_chk(8'h30, 32'h0);
    rd_chk(8'h3c, 32'h0);
    wr(8'h20, 32'hffff);
    wr(8'h30, 32'h7);
    rd_chk(8'h20, 32'h0);
    rd_chk(8'h30, 32'h3);
    repeat (3) pulse(1'h1, 1'h0, 1'h0);
    repeat (2) pulse(1'h0, 1'h1, 1'h0);
    pulse(1'h0, 1'h0, 1'h1);
    pulse(1'h0, 1'h1, 1'h1);
    pulse(1'h1, 1'h1, 1'h0);
    pulse(1'h1, 1'h0, 1'h1);
    rd_chk(8'h20, 32'h3);
    rd_chk(8'h24, 32'h4);
    rd_chk(8'h28, 32'h2);
    rd_chk(8'h40, 32'h3);
    cmp(irq, 1'h0);
    wr(8'h44, 32'h1);
    irq_chk(1'h1);
    wr(8'h40, 32'h3);
    irq_chk(1'h0);
    rd_chk(8'h40, 32'h0);
    pulse(1'h0, 1'h0, 1'h1);
    irq_chk(1'h0);
    pulse(1'h0, 1'h1, 1'h0);
    irq_chk(1'h1);
    map(2'h0, 1'h1, 16'h13ed, 1'h0, 8'h33, 8'h01, 1'h0, 1'h0);
    map(2'h0, 1'h1, 16'h4e1f, 1'h0, 8'hc7, 8'h63, 1'h0, 1'h0);
    map(2'h0, 1'h1, 16'h13ec, 1'h1, 8'h00, 8'h00, 1'h0, 1'h0);
    map(2'h0, 1'h1, 16'h75fa, 1'h0, 8'h33, 8'h01, 1'h1, 1'h1);
    map(2'h0, 1'h1, 16'h75fb, 1'h0, 8'h33, 8'h01, 1'h1, 1'h0);
    map(2'h0, 1'h0, 16'h75fa, 1'h0, 8'h33, 8'h01, 1'h1, 1'h0);
    map(2'h0, 1'h0, 16'h75fb, 1'h0, 8'h33, 8'h01, 1'h1, 1'h1);
    map(2'h0, 1'h1, 16'hea5e, 1'h0, 8'hc7, 8'h63, 1'h1, 1'h1);
    map(2'h0, 1'h1, 16'h75f8, 1'h1, 8'h00, 8'h00, 1'h0, 1'h0);
    map(2'h1, 1'h1, 16'h3301, 1'h0, 8'h33, 8'h01, 1'h0, 1'h0);
    map(2'h1, 1'h1, 16'hffff, 1'h0, 8'hff, 8'hff, 1'h0, 1'h0);
    map(2'h1, 1'h1, 16'h3300, 1'h1, 8'h00, 8'h00, 1'h0, 1'h0);
    map(2'h2, 1'h1, 16'h6602, 1'h0, 8'h33, 8'h01, 1'h1, 1'h1);
    map(2'h2, 1'h1, 16'h6603, 1'h0, 8'h33, 8'h01, 1'h1, 1'h0);
    map(2'h2, 1'h1, 16'hfffe, 1'h0, 8'h7f, 8'hff, 1'h1, 1'h1);
    map(2'h2, 1'h1, 16'h6600, 1'h1, 8'h00, 8'h00, 1'h0, 1'h0);
    map(2'h3, 1'h1, 16'h3302, 1'h0, 8'h33, 8'h01, 1'h1, 1'h1);
    map(2'h3, 1'h1, 16'hfffe, 1'h0, 8'hff, 8'h7f, 1'h1, 1'h1);
    map(2'h3, 1'h1, 16'h0002, 1'h1, 8'h00, 8'h00, 1'h0, 1'h0);
    rd_chk(8'h40, 32'h7);
    @(posedge clk_i);
    rw <= 1'h1;
    b1 <= 8'ha5;
    b2 <= 8'h5a;
    map(2'h1, 1'h1, 16'h3301, 1'h0, 8'h33, 8'h01, 1'h0, 1'h0);
    cmp({pwr, pwd}, {1'h1, 16'ha55a});
    @(posedge clk_i);
    en <= 1'h0;
    pulse(1'h1, 1'h0, 1'h0);
    en <= 1'h1;
    rd_chk(8'h20, 32'h3);
    @(posedge clk_i);
    ok <= 1'h1;
    repeat (65535) @(posedge clk_i);
    ok <= 1'h0;
    rd_chk(8'h20, 32'hffff);
    rd_chk(8'h40, 32'hf);
    wrap_up();
  end
endmodule
